//--- design/quad_wiper_i2c_control.sv
`timescale 1ns/1ns
module quad_wiper_i2c_control
    import wiper_pkg::*;
#(
    parameter logic [BUSY_W-1:0] NV_WRITE_CYCLES = BUSY_W'(NV_WRITE_CYC)
) (
    // clock and reset
    input  wire logic                           i_clk,
    input  wire logic                           i_sys_rst,
    // serial bus
    input  wire logic                           i_scl,
    input  wire logic                           i_sda,
    output logic                                o_sda_out,
    output logic                                o_sda_oe_n,
    // strap pins
    input  wire logic                           i_slave_addr_in0,
    input  wire logic                           i_slave_addr_in1,
    input  wire logic                           i_slave_addr_in2,
    input  wire logic                           i_slave_addr_in3,
    input  wire logic                           i_write_protect_n,
    // potentiometer side
    output logic [N_POTS-1:0][N_TAPS-1:0]       o_tap_sel,
    output logic [N_POTS-1:0][POS_W-1:0]        o_wiper_pos,
    output logic                                o_nv_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    pins_t      pin_meta_q;      // first stage, read only by the second
    pins_t      pin_sync_q;      // usable bus levels
    pins_t      pin_prev_q;      // one cycle older, for edge finding
    logic [4:0] strap_meta_q;    // address pins and write protect, first stage
    logic [4:0] strap_sync_q;    // second stage
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic [3:0] addr_pins;
    logic       wp_open;         // high: saved-setting writes allowed

    // two flops on every pin; the serial clock is sampled, not used as a clock
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pin_meta_q   <= '1;
            pin_sync_q   <= '1;
            pin_prev_q   <= '1;
            strap_meta_q <= '0;
            strap_sync_q <= '0;
        end else begin
            pin_meta_q   <= '{scl: i_scl, sda: i_sda};
            pin_sync_q   <= pin_meta_q;
            pin_prev_q   <= pin_sync_q;
            strap_meta_q <= {i_write_protect_n, i_slave_addr_in3, i_slave_addr_in2,
                             i_slave_addr_in1, i_slave_addr_in0};
            strap_sync_q <= strap_meta_q;
        end
    end

    // edges of the serial clock and bus conditions
    assign scl_rise  = pin_sync_q.scl & ~pin_prev_q.scl;
    assign scl_fall  = ~pin_sync_q.scl & pin_prev_q.scl;
    assign bus_start = pin_sync_q.scl & pin_prev_q.scl & pin_prev_q.sda & ~pin_sync_q.sda;
    assign bus_stop  = pin_sync_q.scl & pin_prev_q.scl & ~pin_prev_q.sda & pin_sync_q.sda;
    assign addr_pins = strap_sync_q[3:0];
    assign wp_open   = strap_sync_q[4];

    ////////////////////////////////////////////////////////////////////////////
    // protocol state and register file
    state_t                                  state_q, state_d;
    state_t                                  after_q, after_d;   // state after the ack bit
    logic [3:0]                              cnt_q, cnt_d;       // bits of current byte
    logic [7:0]                              shift_q, shift_d;   // byte in or out
    instr_t                                  instr_q, instr_d;   // last instruction
    logic                                    drive_q, drive_d;   // pull data line low
    logic [BUSY_W-1:0]                       busy_q, busy_d;     // write cycle remaining
    logic                                    load_q, load_d;     // power-up recall pending
    logic [N_POTS-1:0][POS_W-1:0]            wiper_q, wiper_d;   // wiper_position_reg
    logic [N_POTS-1:0][N_SAVED-1:0][POS_W-1:0] saved_q, saved_d; // saved_setting_reg
    logic [N_POTS-1:0][N_TAPS-1:0]           tap_q, tap_d;       // one-hot tap switches

    // next-state logic for the whole bus engine
    always_comb begin
        instr_t ins;
        logic   ack;
        ins     = instr_t'(shift_q);
        ack     = 1'b0;
        state_d = state_q;
        after_d = after_q;
        cnt_d   = cnt_q;
        shift_d = shift_q;
        instr_d = instr_q;
        drive_d = drive_q;
        busy_d  = busy_q;
        load_d  = 1'b0;
        wiper_d = wiper_q;
        saved_d = saved_q;
        // write cycle runs down on its own
        if (busy_q != BUSY_ZERO) begin
            busy_d = busy_q - BUSY_ONE;
        end
        // first clock after reset: recall the first saved setting
        if (load_q) begin
            for (int p = 0; p < N_POTS; p++) begin
                wiper_d[p] = saved_q[p][0];
            end
        end
        if (bus_start) begin
            // a start wins over anything in progress
            state_d = ST_ADDR;
            cnt_d   = '0;
            drive_d = 1'b0;
        end else if (bus_stop) begin
            state_d = ST_IDLE;
            drive_d = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_d = ST_IDLE;
                end
                // receiving states share the shifter
                ST_ADDR, ST_INSTR, ST_RX: begin
                    if (scl_rise && cnt_q != BYTE_BITS) begin
                        shift_d = {shift_q[6:0], pin_sync_q.sda};
                        cnt_d   = cnt_q + CNT_ONE;
                    end else if (scl_fall && cnt_q == BYTE_BITS) begin
                        cnt_d = '0;
                        if (state_q == ST_ADDR) begin
                            // write direction only; stay silent while busy or loading
                            ack     = (shift_q == {FAMILY_CODE, addr_pins, 1'b0})
                                      && busy_q == BUSY_ZERO && !load_q;
                            after_d = ST_INSTR;
                        end else if (state_q == ST_INSTR) begin
                            instr_d = ins;
                            ack     = 1'b1;
                            after_d = ST_IDLE;
                            case (ins.op)
                                OP_RD_WIPER: begin
                                    shift_d = {2'b00, wiper_q[ins.pot]};
                                    after_d = ST_TX;
                                end
                                OP_RD_SAVED: begin
                                    shift_d = {2'b00, saved_q[ins.pot][ins.idx]};
                                    after_d = ST_TX;
                                end
                                OP_WR_WIPER, OP_WR_SAVED, OP_STEP: begin
                                    after_d = ST_RX;
                                end
                                OP_RECALL: begin
                                    wiper_d[ins.pot] = saved_q[ins.pot][ins.idx];
                                end
                                OP_STORE: begin
                                    ack = wp_open;
                                    if (wp_open) begin
                                        saved_d[ins.pot][ins.idx] = wiper_q[ins.pot];
                                        busy_d = NV_WRITE_CYCLES;
                                    end
                                end
                                default: begin
                                    ack = 1'b0;
                                end
                            endcase
                        end else begin
                            ack     = 1'b1;
                            after_d = ST_IDLE;
                            case (instr_q.op)
                                OP_WR_WIPER: begin
                                    // wiper changes are allowed even when protected
                                    wiper_d[instr_q.pot] = shift_q[POS_W-1:0];
                                end
                                OP_WR_SAVED: begin
                                    ack = wp_open;
                                    if (wp_open) begin
                                        saved_d[instr_q.pot][instr_q.idx] = shift_q[POS_W-1:0];
                                        busy_d = NV_WRITE_CYCLES;
                                    end
                                end
                                OP_STEP: begin
                                    // one step per byte, bit 0 picks the direction
                                    after_d = ST_RX;
                                    if (shift_q[0] && wiper_q[instr_q.pot] != POS_MAX) begin
                                        wiper_d[instr_q.pot] = wiper_q[instr_q.pot] + POS_ONE;
                                    end else if (!shift_q[0]
                                                 && wiper_q[instr_q.pot] != POS_MIN) begin
                                        wiper_d[instr_q.pot] = wiper_q[instr_q.pot] - POS_ONE;
                                    end
                                end
                                default: begin
                                    ack = 1'b0;
                                end
                            endcase
                        end
                        drive_d = ack;
                        state_d = ack ? ST_ACK : ST_IDLE;
                    end
                end
                // hold the ack low for one bit, then release or send
                ST_ACK: begin
                    if (scl_fall) begin
                        state_d = after_q;
                        cnt_d   = '0;
                        drive_d = 1'b0;
                        if (after_q == ST_TX) begin
                            drive_d = ~shift_q[7];
                            shift_d = {shift_q[6:0], 1'b0};
                            cnt_d   = CNT_ONE;
                        end
                    end
                end
                // data out, msb first, changed on falling clock
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == BYTE_BITS) begin
                            drive_d = 1'b0;
                            state_d = ST_MACK;
                        end else begin
                            drive_d = ~shift_q[7];
                            shift_d = {shift_q[6:0], 1'b0};
                            cnt_d   = cnt_q + CNT_ONE;
                        end
                    end
                end
                // master's ack or nack ends the read either way
                ST_MACK: begin
                    if (scl_rise) begin
                        state_d = ST_IDLE;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    drive_d = 1'b0;
                end
            endcase
        end
    end

    // tap decode: a shift of a single one can never close two switches
    for (genvar g = 0; g < N_POTS; g++) begin : g_tap
        assign tap_d[g] = TAP_ONE << wiper_d[g];
    end

    // registers of the bus engine and the register file
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= ST_IDLE;
            after_q <= ST_IDLE;
            cnt_q   <= '0;
            shift_q <= '0;
            instr_q <= '0;
            drive_q <= 1'b0;
            busy_q  <= BUSY_ZERO;
            load_q  <= 1'b1;
            wiper_q <= {N_POTS{WIPER_RESET}};
            saved_q <= {(N_POTS * N_SAVED){SAVED_RESET}};
            tap_q   <= {N_POTS{TAP_ONE}};
        end else begin
            state_q <= state_d;
            after_q <= after_d;
            cnt_q   <= cnt_d;
            shift_q <= shift_d;
            instr_q <= instr_d;
            drive_q <= drive_d;
            busy_q  <= busy_d;
            load_q  <= load_d;
            wiper_q <= wiper_d;
            saved_q <= saved_d;
            tap_q   <= tap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_sda_out   = 1'b0;        // only ever pulls low
    assign o_sda_oe_n  = ~drive_q;
    assign o_tap_sel   = tap_q;
    assign o_wiper_pos = wiper_q;
    assign o_nv_busy   = (busy_q != BUSY_ZERO);

endmodule

//--- design/wiper_pkg.sv
package wiper_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and non-volatile write timing
    localparam int CLK_PERIOD_NS = 100;      // system clock period
    localparam int NV_WRITE_NS   = 5000000;  // internal non-volatile write cycle
    // least time, so round up to whole cycles
    localparam int NV_WRITE_CYC  = (NV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_W        = 16;       // width of the write-cycle counter

    ////////////////////////////////////////////////////////////////////////////
    // array geometry
    localparam int N_POTS  = 4;   // potentiometers
    localparam int N_SAVED = 4;   // saved settings per potentiometer
    localparam int POS_W   = 6;   // wiper position width
    localparam int N_TAPS  = 64;  // 63 series elements give 64 taps

    ////////////////////////////////////////////////////////////////////////////
    // values
    localparam logic [3:0]        BYTE_BITS   = 4'h8;
    localparam logic [3:0]        CNT_ONE     = 4'h1;
    localparam logic [2:0]        FAMILY_CODE = 3'h5;  // arbitrary fixed address part
    localparam logic [POS_W-1:0]  WIPER_RESET = 6'h00;
    localparam logic [POS_W-1:0]  SAVED_RESET = 6'h20;
    localparam logic [POS_W-1:0]  POS_MAX     = 6'h3f;
    localparam logic [POS_W-1:0]  POS_MIN     = 6'h00;
    localparam logic [POS_W-1:0]  POS_ONE     = 6'h01;
    localparam logic [N_TAPS-1:0] TAP_ONE     = 64'h1;
    localparam logic [BUSY_W-1:0] BUSY_ONE    = 16'h1;
    localparam logic [BUSY_W-1:0] BUSY_ZERO   = 16'h0;

    ////////////////////////////////////////////////////////////////////////////
    // instruction opcodes (upper nibble of the instruction byte)
    localparam logic [3:0] OP_RD_WIPER = 4'h9;  // read wiper position
    localparam logic [3:0] OP_WR_WIPER = 4'ha;  // write wiper position
    localparam logic [3:0] OP_RD_SAVED = 4'hb;  // read saved setting
    localparam logic [3:0] OP_WR_SAVED = 4'hc;  // write saved setting
    localparam logic [3:0] OP_RECALL   = 4'hd;  // saved setting -> wiper
    localparam logic [3:0] OP_STORE    = 4'he;  // wiper -> saved setting
    localparam logic [3:0] OP_STEP     = 4'h2;  // increment/decrement mode

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic [3:0] op;   // opcode
        logic [1:0] pot;  // potentiometer select
        logic [1:0] idx;  // saved setting select
    } instr_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } pins_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_INSTR, ST_RX, ST_TX, ST_MACK
    } state_t;

endpackage

//--- verif/i2c_master_model.sv
`timescale 1ns/1ns
// bus master on the far side: drives the clock, only ever pulls data low
module i2c_master_model (
    // bus pins
    output logic      o_scl,
    output logic      o_sda_oe_n,  // low = master pulls data low
    input  wire logic i_sda        // resolved wire, pulled up
);
    localparam int Q = 200;  // quarter of the 800 ns bus clock
    // idle bus: both lines high, clock stands still between frames
    initial begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    // odd offset keeps the bus clock out of phase with the system clock
    task automatic start();
        #37 o_sda_oe_n = 1'b0;  // data falls while clock high
        #Q o_scl = 1'b0;
    endtask
    // data changes mid-low, sampled at the end of high, well clear of sync lag
    task automatic bit_x(input logic b, output logic r);
        #Q o_sda_oe_n = b;
        #Q o_scl = 1'b1;
        #(2*Q) r = i_sda;
        o_scl = 1'b0;
    endtask
    // msb first, then release for the acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], r);
        end
        bit_x(1'b1, r);
        ack = !r;
    endtask
    // nack high ends a read
    task automatic recv_byte(input logic nack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            b[i] = r;
        end
        bit_x(nack, r);
    endtask
    // data rises while clock high, then the bus idles
    task automatic stop();
        #Q o_sda_oe_n = 1'b0;
        #Q o_scl = 1'b1;
        #Q o_sda_oe_n = 1'b1;
        #(2*Q);
    endtask
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ns
// master model on the bus, integer reference of every register beside it
module tb_top;
    import wiper_pkg::*;
    localparam logic [BUSY_W-1:0] NV_CYC = 16'h00c8;  // short write cycle keeps the run brief
    logic                          clk = 1'b0;
    logic                          rst = 1'b1;
    logic                          wp_n = 1'b1;  // floating pin reads high
    logic [3:0]                    straps = 4'h0;
    logic                          scl, m_oe_n, sda_out, sda_oe_n, nv_busy;
    logic [N_POTS-1:0][N_TAPS-1:0] tap_sel;
    logic [N_POTS-1:0][POS_W-1:0]  wiper_pos;
    wire logic                     sda;
    logic [7:0]                    dev_addr, rdv;
    logic [2:0]                    acks;
    logic [31:0]                   sdat;
    int                            v, sn, mismatches = 0, n_compared = 0;
    int                            wip[N_POTS];          // reference wipers
    int                            sav[N_POTS*N_SAVED];  // reference saved settings
    assign sda = (sda_oe_n | sda_out) & m_oe_n;  // pulled-up wire
    always #50 clk = ~clk;
    quad_wiper_i2c_control #(.NV_WRITE_CYCLES(NV_CYC)) quad_wiper_i2c_control_inst (
        .i_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
        .o_sda_oe_n(sda_oe_n), .i_slave_addr_in0(straps[0]), .i_slave_addr_in1(straps[1]),
        .i_slave_addr_in2(straps[2]), .i_slave_addr_in3(straps[3]),
        .i_write_protect_n(wp_n), .o_tap_sel(tap_sel), .o_wiper_pos(wiper_pos),
        .o_nv_busy(nv_busy));
    i2c_master_model i2c_master_model_inst (.o_scl(scl), .o_sda_oe_n(m_oe_n), .i_sda(sda));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // address, instruction, then n data bytes; acks {addr, instr, last data}
    task automatic frame(input logic [7:0] adr, input logic [7:0] ins, input logic [31:0] dat,
                         input int n, output logic [2:0] ak);
        logic a;
        ak = 3'h0;
        i2c_master_model_inst.start();
        i2c_master_model_inst.send_byte(adr, a);
        ak[2] = a;
        if (a) begin
            i2c_master_model_inst.send_byte(ins, a);
            ak[1] = a;
            for (int i = 0; i < n; i++) begin
                i2c_master_model_inst.send_byte(dat[8*i +: 8], a);
                ak[0] = a;
            end
        end
        i2c_master_model_inst.stop();
    endtask
    // read instruction, one byte back, nack, stop
    task automatic rd(input logic [7:0] ins, output logic [7:0] b);
        logic a;
        i2c_master_model_inst.start();
        i2c_master_model_inst.send_byte(dev_addr, a);
        i2c_master_model_inst.send_byte(ins, a);
        i2c_master_model_inst.recv_byte(1'b1, b);
        i2c_master_model_inst.stop();
    endtask
    task automatic check_pots();
        for (int p = 0; p < N_POTS; p++) begin
            check(64'(wiper_pos[p]), 64'(wip[p]));
            check(tap_sel[p], 64'h1 << wip[p]);
        end
    endtask
    // bounded wait for the write cycle to end
    task automatic wait_nv();
        for (int i = 0; i < 400 && nv_busy !== 1'b0; i++) begin
            @(posedge clk);
            #5;
        end
        check(64'(nv_busy), 64'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        v = $urandom(19654);
        straps = 4'($urandom % 16);
        dev_addr = {FAMILY_CODE, straps, 1'b0};
        foreach (sav[r]) sav[r] = int'(SAVED_RESET);
        foreach (wip[p]) wip[p] = int'(SAVED_RESET);
        repeat (2) @(posedge clk);
        #5 rst = 1'b0;
        repeat (10) @(posedge clk);
        #5 check_pots();
        // read direction, then each strap bit flipped in turn, must be ignored
        for (int b = 0; b < 5; b++) begin
            frame(dev_addr ^ (8'h01 << b), {OP_WR_WIPER, 4'h0}, 32'h3f, 1, acks);
            check(64'(acks), 64'h0);
        end
        for (int p = 0; p < N_POTS; p++) begin
            v = $urandom % 64;
            wip[p] = v;
            frame(dev_addr, {OP_WR_WIPER, 2'(p), 2'h0}, 32'(v), 1, acks);
            check(64'(acks), 64'h7);
            check_pots();
            rd({OP_RD_WIPER, 2'(p), 2'h0}, rdv);
            check(64'(rdv), 64'(v));
        end
        // all sixteen saved settings; address refused while the write runs
        for (int r = 0; r < N_POTS*N_SAVED; r++) begin
            sav[r] = $urandom % 64;
            frame(dev_addr, {OP_WR_SAVED, 4'(r)}, 32'(sav[r]), 1, acks);
            check(64'(acks), 64'h7);
            frame(dev_addr, {OP_RD_WIPER, 4'h0}, 32'h0, 0, acks);
            check(64'(acks), 64'h0);
            wait_nv();
        end
        for (int r = 0; r < N_POTS*N_SAVED; r++) begin
            rd({OP_RD_SAVED, 4'(r)}, rdv);
            check(64'(rdv), 64'(sav[r]));
        end
        // protect low: saved writes and stores refused, wiper writes still taken
        @(posedge clk);
        #5 wp_n = 1'b0;
        frame(dev_addr, {OP_WR_SAVED, 4'h1}, 32'(sav[1] ^ 1), 1, acks);
        check(64'(acks), 64'h6);
        frame(dev_addr, {OP_STORE, 4'h1}, 32'h0, 0, acks);
        check(64'(acks), 64'h4);
        wait_nv();
        rd({OP_RD_SAVED, 4'h1}, rdv);
        check(64'(rdv), 64'(sav[1]));
        wip[0] = $urandom % 64;
        frame(dev_addr, {OP_WR_WIPER, 4'h0}, 32'(wip[0]), 1, acks);
        check(64'(acks), 64'h7);
        check_pots();
        @(posedge clk);
        #5 wp_n = 1'b1;
        // moves between wiper and saved settings, both ways
        frame(dev_addr, {OP_RECALL, 4'hb}, 32'h0, 0, acks);
        wip[2] = sav[11];
        check(64'(acks), 64'h6);
        check_pots();
        frame(dev_addr, {OP_STORE, 4'hd}, 32'h0, 0, acks);
        sav[13] = wip[3];
        wait_nv();
        rd({OP_RD_SAVED, 4'hd}, rdv);
        check(64'(rdv), 64'(sav[13]));
        // stepping against both ends; a wrapping counter gives other results
        for (int c = 0; c < 2; c++) begin
            wip[1] = (c == 0) ? 62 : 1;
            sdat = (c == 0) ? 32'h00000101 : 32'h00010000;
            sn = 4 - c;
            frame(dev_addr, {OP_WR_WIPER, 4'h4}, 32'(wip[1]), 1, acks);
            frame(dev_addr, {OP_STEP, 4'h4}, sdat, sn, acks);
            for (int i = 0; i < sn; i++) begin
                wip[1] = sdat[8*i] ? ((wip[1] < 63) ? wip[1] + 1 : 63)
                                   : ((wip[1] > 0) ? wip[1] - 1 : 0);
            end
            check(64'(acks), 64'h7);
            check_pots();
        end
        end_sim();
    end
    // hang guard, about two and a half times the expected run
    initial begin
        #4000000;
        mismatches++;
        end_sim();
    end
endmodule

//--- verif/wiper_checker_assertions.sv
`timescale 1ns/1ns
// watches the block from its ports only; the bus clock is seen raw, before any sync
module wiper_checker
    import wiper_pkg::*;
#(
    parameter logic [BUSY_W-1:0] NV_WRITE_CYCLES = BUSY_W'(NV_WRITE_CYC)
) (
    // clock, reset and bus
    input wire logic                          i_clk,
    input wire logic                          i_sys_rst,
    input wire logic                          i_scl,
    input wire logic                          o_sda_out,
    input wire logic                          o_sda_oe_n,
    // potentiometer side
    input wire logic [N_POTS-1:0][N_TAPS-1:0] o_tap_sel,
    input wire logic [N_POTS-1:0][POS_W-1:0]  o_wiper_pos,
    input wire logic                          o_nv_busy
);
    logic [3:0]        scl_hi_q;  // clocks the bus clock stayed high, saturating
    logic [3:0]        scl_hi_d;
    logic [BUSY_W-1:0] busy_q;    // clocks the write cycle has run
    logic [BUSY_W-1:0] busy_d;
    // a long high bus clock can only mean an idle bus, so neither the data line nor the wipers may move then
    always_comb begin
        scl_hi_d = (scl_hi_q == 4'hf) ? scl_hi_q : scl_hi_q + 4'h1;
        if (!i_scl) begin
            scl_hi_d = 4'h0;
        end
        busy_d = o_nv_busy ? busy_q + BUSY_ONE : BUSY_ZERO;
    end
    // helper registers
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            scl_hi_q <= 4'h0;
            busy_q   <= BUSY_ZERO;
        end else begin
            scl_hi_q <= scl_hi_d;
            busy_q   <= busy_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    a_sda_low_only: assert property (o_sda_out == 1'b0)
        else $error("data output is not low");
    a_bus_idle_release: assert property (scl_hi_q >= 4'h8 |-> o_sda_oe_n)
        else $error("data pulled low on an idle bus");
    a_wiper_idle_stable: assert property (scl_hi_q >= 4'h8 |-> $stable(o_wiper_pos))
        else $error("wiper moved without bus clocking");
    a_powerup_load: assert property ($fell(i_sys_rst) |=> o_wiper_pos == {N_POTS{SAVED_RESET}})
        else $error("wipers not loaded from first saved setting");
    a_busy_length: assert property ($fell(o_nv_busy) |-> busy_q == NV_WRITE_CYCLES)
        else $error("write cycle length wrong");
    a_busy_no_ack: assert property (busy_q >= 16'h000c |-> o_sda_oe_n)
        else $error("acknowledge during write cycle");
    // per potentiometer: one tap, and it tracks the wiper in the same clock,
    // since the tap decode is fed from the wiper's next value
    for (genvar p = 0; p < N_POTS; p++) begin : g_pot
        a_taps_one_hot: assert property ($onehot(o_tap_sel[p]))
            else $error("tap select not one-hot");
        a_tap_follows_wiper: assert property (
            o_tap_sel[p] == (TAP_ONE << o_wiper_pos[p]))
            else $error("tap does not follow wiper");
    end
    c_write_cycle: cover property ($rose(o_nv_busy));
    c_device_drive: cover property ($fell(o_sda_oe_n));
    c_wiper_move: cover property (!$stable(o_wiper_pos));
endmodule

bind quad_wiper_i2c_control wiper_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) wiper_checker_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .o_sda_out(o_sda_out),
    .o_sda_oe_n(o_sda_oe_n), .o_tap_sel(o_tap_sel), .o_wiper_pos(o_wiper_pos),
    .o_nv_busy(o_nv_busy)
);
